// ---- core/sbf_core.sv ----
`timescale 1ns/1ps
module sbf_core (
    input wire logic pclk,                  // bus clock, 20 MHz
    input wire logic presetn,               // async reset, active low
    input wire logic psel,                  // apb select
    input wire logic penable,               // apb enable
    input wire logic pwrite,                // apb direction
    input wire logic [7:0] paddr,           // apb byte address
    input wire logic [31:0] pwdata,         // apb write data
    output logic [31:0] prdata,             // apb read data
    output logic pready,                    // apb ready
    output logic pslverr,                   // apb error, unmapped address
    input wire logic ss_in_n,               // slave select pin level, active low
    input wire logic xfer_done,             // shifter finished a byte, pulse
    input wire logic [7:0] rx_shift_byte,   // byte received by the shifter
    output logic shift_load,                // byte handed to shifter, pulse
    output logic [7:0] shift_data,          // byte for the shifter
    output logic baud_tick,                 // master bit rate enable, pulse
    output logic irq                        // interrupt request, level
);

    // ****************************************
    // registers
    // ****************************************
    sbf_pkg::sbf_ctrl1_t ctrl1_r;
    sbf_pkg::sbf_flags_t flags_r;
    logic [7:0] ctrl2_r;
    logic [7:0] baud_r;
    logic [7:0] tx_buf_r;
    logic [7:0] rx_buf_r;
    logic shift_busy_r;
    logic tx_arm_r;
    logic rx_arm_r;
    logic mode_fault_flag_arm_r;
    logic ss_prev_r;
    logic [2:0] pre_cnt_r;
    logic [7:0] div_cnt_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic shift_load_r;
    logic [7:0] shift_data_r;
    logic baud_tick_r;
    logic irq_r;
    logic [7:0] rd_byte;
    logic rd_hit;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] div_limit(input logic [2:0] sel);
        logic [8:0] v;
        v = (9'h002 << sel) - 9'h001;
        return v[7:0];
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // ****************************************
    // apb decode
    // ****************************************
    logic setup;
    logic access;
    logic wr_ctrl1;
    logic wr_ctrl2;
    logic wr_baud;
    logic wr_data;
    logic rd_status;
    logic rd_data;
    logic sys_en;
    logic data_ok;
    logic move_tx;
    logic fault_edge;
    logic pre_tick;
    logic [2:0] pre_sel;
    logic [2:0] div_sel;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready_r;
    assign wr_ctrl1 = access & pwrite & hit(paddr, sbf_pkg::ADDR_CTRL1);
    assign wr_ctrl2 = access & pwrite & hit(paddr, sbf_pkg::ADDR_CTRL2);
    assign wr_baud = access & pwrite & hit(paddr, sbf_pkg::ADDR_BAUD);
    assign wr_data = access & pwrite & hit(paddr, sbf_pkg::ADDR_DATA);
    assign rd_status = access & ~pwrite & hit(paddr, sbf_pkg::ADDR_STATUS);
    assign rd_data = access & ~pwrite & hit(paddr, sbf_pkg::ADDR_DATA);
    assign sys_en = ctrl1_r.system_enable;
    // write accepted only after an armed status read
    assign data_ok = wr_data & tx_arm_r & flags_r.tx_empty_flag & sys_en;
    // buffer holds a byte and shifter is free
    assign move_tx = sys_en & ~flags_r.tx_empty_flag & ~shift_busy_r;
    assign fault_edge = sys_en & ctrl1_r.master_select & ctrl2_r[sbf_pkg::CTRL2_FEN_BIT]
                        & ~ctrl1_r.select_output_enable & ss_prev_r & ~ss_in_n;
    assign pre_sel = baud_r[sbf_pkg::BAUD_PRE_LSB +: 3];
    assign div_sel = baud_r[sbf_pkg::BAUD_DIV_LSB +: 3];

    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (paddr)
            sbf_pkg::ADDR_CTRL1: rd_byte = ctrl1_r;
            sbf_pkg::ADDR_CTRL2: rd_byte = ctrl2_r;
            sbf_pkg::ADDR_BAUD: rd_byte = baud_r;
            sbf_pkg::ADDR_STATUS: begin
                // unused bits stay zero
                rd_byte[sbf_pkg::STS_RXF_BIT] = flags_r.rx_full_flag;
                rd_byte[sbf_pkg::STS_TXE_BIT] = flags_r.tx_empty_flag;
                rd_byte[sbf_pkg::STS_MODE_FAULT_FLAG_BIT] = flags_r.mode_fault_flag;
            end
            sbf_pkg::ADDR_DATA: rd_byte = rx_buf_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // apb response, one wait-free access phase
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= setup;
            if (setup) begin
                pslverr_r <= ~rd_hit;
                prdata_r <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
            end
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_r <= sbf_pkg::CTRL1_RST;
            ctrl2_r <= sbf_pkg::CTRL2_RST;
            baud_r <= sbf_pkg::BAUD_RST;
        end else begin
            if (wr_ctrl1) begin
                ctrl1_r <= pwdata[7:0];
            end
            if (wr_ctrl2) begin
                ctrl2_r <= pwdata[7:0] & sbf_pkg::CTRL2_MASK;
            end
            // no dependency on transfer state
            if (wr_baud) begin
                baud_r <= pwdata[7:0] & sbf_pkg::BAUD_MASK;
            end
        end
    end

    // ****************************************
    // bit rate generator
    // ****************************************
    assign pre_tick = pre_cnt_r == pre_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_r <= 3'h0;
            div_cnt_r <= 8'h00;
            baud_tick_r <= 1'b0;
        end else if (!sys_en || !ctrl1_r.master_select) begin
            pre_cnt_r <= 3'h0;
            div_cnt_r <= 8'h00;
            baud_tick_r <= 1'b0;
        end else begin
            baud_tick_r <= 1'b0;
            if (pre_tick) begin
                pre_cnt_r <= 3'h0;
                if (div_cnt_r >= div_limit(div_sel)) begin
                    div_cnt_r <= 8'h00;
                    baud_tick_r <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 8'h01;
                end
            end else begin
                pre_cnt_r <= pre_cnt_r + 3'h1;
            end
        end
    end

    // ****************************************
    // transmit path
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r.tx_empty_flag <= sbf_pkg::FLAGS_RST.tx_empty_flag;
            tx_arm_r <= 1'b0;
            tx_buf_r <= sbf_pkg::DATA_RST;
            shift_busy_r <= 1'b0;
            shift_load_r <= 1'b0;
            shift_data_r <= sbf_pkg::DATA_RST;
        end else if (!sys_en) begin
            flags_r.tx_empty_flag <= 1'b1;
            tx_arm_r <= 1'b0;
            shift_busy_r <= 1'b0;
            shift_load_r <= 1'b0;
        end else begin
            shift_load_r <= 1'b0;
            if (rd_status && prdata_r[sbf_pkg::STS_TXE_BIT]) begin
                tx_arm_r <= 1'b1;
            end
            if (data_ok) begin
                tx_buf_r <= pwdata[7:0];
                flags_r.tx_empty_flag <= 1'b0;
                tx_arm_r <= 1'b0;
            end else if (move_tx) begin
                shift_data_r <= tx_buf_r;
                shift_load_r <= 1'b1;
                shift_busy_r <= 1'b1;
                flags_r.tx_empty_flag <= 1'b1;
            end
            if (xfer_done && !move_tx) begin
                shift_busy_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // receive path
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r.rx_full_flag <= sbf_pkg::FLAGS_RST.rx_full_flag;
            rx_arm_r <= 1'b0;
            rx_buf_r <= sbf_pkg::DATA_RST;
        end else if (!sys_en) begin
            flags_r.rx_full_flag <= 1'b0;
            rx_arm_r <= 1'b0;
        end else begin
            if (rd_status && prdata_r[sbf_pkg::STS_RXF_BIT]) begin
                rx_arm_r <= 1'b1;
            end
            if (rd_data && rx_arm_r) begin
                flags_r.rx_full_flag <= 1'b0;
                rx_arm_r <= 1'b0;
            end
            // set wins; a full buffer keeps its byte
            if (xfer_done && (!flags_r.rx_full_flag || (rd_data && rx_arm_r))) begin
                rx_buf_r <= rx_shift_byte;
                flags_r.rx_full_flag <= 1'b1;
            end
        end
    end

    // ****************************************
    // mode fault
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r.mode_fault_flag <= sbf_pkg::FLAGS_RST.mode_fault_flag;
            mode_fault_flag_arm_r <= 1'b0;
            ss_prev_r <= 1'b1;
        end else begin
            ss_prev_r <= ss_in_n;
            if (rd_status && prdata_r[sbf_pkg::STS_MODE_FAULT_FLAG_BIT]) begin
                mode_fault_flag_arm_r <= 1'b1;
            end
            if (wr_ctrl1 && mode_fault_flag_arm_r) begin
                flags_r.mode_fault_flag <= 1'b0;
                mode_fault_flag_arm_r <= 1'b0;
            end
            if (fault_edge) begin
                flags_r.mode_fault_flag <= 1'b1;
            end
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (flags_r.tx_empty_flag & ctrl1_r.tx_irq_enable)
                     | ((flags_r.rx_full_flag | flags_r.mode_fault_flag)
                        & ctrl1_r.rx_fault_irq_enable);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign shift_load = shift_load_r;
    assign shift_data = shift_data_r;
    assign baud_tick = baud_tick_r;
    assign irq = irq_r;

    // ****************************************
    // assertions
    // ****************************************
    a_load_sets_empty: assert property (@(posedge pclk) disable iff (!presetn)
        shift_load_r |-> flags_r.tx_empty_flag && shift_busy_r)
        else $error("shifter load without tx empty flag");

    a_unarmed_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_data && !tx_arm_r && flags_r.tx_empty_flag) |=> flags_r.tx_empty_flag)
        else $error("unarmed data write was accepted");

    a_idle_refill: assert property (@(posedge pclk) disable iff (!presetn)
        (data_ok && !shift_busy_r && !xfer_done) |=> !flags_r.tx_empty_flag ##1
        (flags_r.tx_empty_flag && shift_load_r))
        else $error("idle byte not moved within two cycles");

    a_rx_set: assert property (@(posedge pclk) disable iff (!presetn)
        (xfer_done && sys_en && !flags_r.rx_full_flag) |=>
        flags_r.rx_full_flag && rx_buf_r == $past(rx_shift_byte))
        else $error("rx full flag not set on transfer end");

    a_rx_overrun: assert property (@(posedge pclk) disable iff (!presetn)
        (xfer_done && sys_en && flags_r.rx_full_flag && !rd_data) |=> $stable(rx_buf_r))
        else $error("unread receive byte overwritten");

    a_rx_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_data && rx_arm_r && !xfer_done) |=> !flags_r.rx_full_flag)
        else $error("rx full flag not cleared");

    a_mode_fault_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flags_r.mode_fault_flag) |-> $past(fault_edge))
        else $error("mode fault without a fault edge");

    a_mode_fault_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl1 && mode_fault_flag_arm_r && !fault_edge) |=> !flags_r.mode_fault_flag)
        else $error("mode fault flag not cleared");

    a_disable_flags: assert property (@(posedge pclk) disable iff (!presetn)
        !sys_en |=> flags_r.tx_empty_flag && !flags_r.rx_full_flag && !shift_busy_r)
        else $error("disable did not reset buffers");

    a_irq_cause: assert property (@(posedge pclk) disable iff (!presetn)
        irq_r |-> $past(flags_r.tx_empty_flag && ctrl1_r.tx_irq_enable)
        || $past((flags_r.rx_full_flag || flags_r.mode_fault_flag)
        && ctrl1_r.rx_fault_irq_enable))
        else $error("interrupt without a cause");

    a_baud_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (baud_tick_r && !wr_baud && !wr_ctrl1) |=> !baud_tick_r)
        else $error("bit rate ticks back to back");

endmodule

// ---- core/sbf_pkg.sv ----
// Overview of operation
// - prescaler divides bus clock by prescale_select plus one, 1 to 8.
// - divider divides prescaler output by 2 to 256, giving master bit rate.
// - bit_rate_config is readable and writable at any time.
// - status unused bits read zero; status writes change no flag.
// - rx_full_flag sets when a transfer completes.
// - rx_full_flag clears by status read with flag set, then data read.
// - tx_empty_flag sets when buffer byte moves into the shifter.
// - tx_empty_flag clears by status read with flag set, then data write.
// - data write ignored unless status was read with tx_empty_flag one.
// - interrupt request while tx_empty_flag and tx_irq_enable are set.
// - idle port moves written byte at once; tx_empty_flag back within two cycles.
// - after a byte finishes, a queued byte moves to shifter automatically.
// - with no queued byte, tx_empty_flag stays set and nothing moves.
// - mode_fault_flag sets on select falling edge in master, fault enabled, output off.
// - mode_fault_flag clears by status read with flag set, then control one write.
// - interrupt request while rx_full or mode_fault set and rx_fault enable set.
// - clearing system_enable aborts, empties buffers, clears rx_full, sets tx_empty.
// - transfer ending with unread receive data discards the new byte silently.
package sbf_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_BAUD = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int STS_RXF_BIT = 7;
    localparam int STS_TXE_BIT = 5;
    localparam int STS_MODE_FAULT_FLAG_BIT = 4;
    localparam int BAUD_PRE_LSB = 4;
    localparam int BAUD_DIV_LSB = 0;
    localparam int CTRL2_FEN_BIT = 4;
    localparam logic [7:0] BAUD_MASK = 8'h77;
    localparam logic [7:0] CTRL2_MASK = 8'h1B;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef struct packed {
        logic rx_fault_irq_enable;
        logic system_enable;
        logic tx_irq_enable;
        logic master_select;
        logic clk_polarity;
        logic clk_phase;
        logic select_output_enable;
        logic lsb_first;
    } sbf_ctrl1_t;

    typedef struct packed {
        logic rx_full_flag;
        logic tx_empty_flag;
        logic mode_fault_flag;
    } sbf_flags_t;

    localparam sbf_flags_t FLAGS_RST = '{rx_full_flag: 1'b0, tx_empty_flag: 1'b1,
                                         mode_fault_flag: 1'b0};

endpackage

// ---- verification/sbf_shifter_model.sv ----
`timescale 1ns/1ps
// ****************************************
// shifter stand-in: finishes each loaded byte after DLY cycles
// ****************************************
module sbf_shifter_model #(
    parameter int DLY = 20
) (
    input wire logic pclk,               // bus clock
    input wire logic presetn,            // async reset, active low
    input wire logic halt,               // drop any byte in flight
    input wire logic shift_load,         // byte handed over
    input wire logic [7:0] shift_data,   // byte to shift
    output logic xfer_done,              // byte finished, pulse
    output logic [7:0] rx_shift_byte     // received byte
);
    int cnt;
    logic [7:0] held;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            held <= 8'h00;
            xfer_done <= 1'h0;
            rx_shift_byte <= 8'h00;
        end else begin
            xfer_done <= 1'h0;
            // outside a completion the byte lines carry no meaning
            rx_shift_byte <= rx_shift_byte + 8'h3B;
            if (halt) begin
                cnt <= 0;
            end else if (shift_load) begin
                cnt <= DLY;
                held <= shift_data;
            end else if (cnt == 1) begin
                cnt <= 0;
                xfer_done <= 1'h1;
                rx_shift_byte <= ~held;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// ---- verification/spi_baud_and_status_flags_bench.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module spi_baud_and_status_flags_bench;
    logic pclk, presetn, psel, penable, pwrite, ss_in_n, halt;
    logic pready, pslverr, xfer_done, shift_load, baud_tick, irq;
    logic [7:0] paddr, rx_shift_byte, shift_data, last;
    logic [31:0] pwdata, prdata, d;
    logic e;
    int loads = 0;
    int cyc = 0;
    int bad_count = 0;
    int checks_done = 0;

    sbf_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ss_in_n(ss_in_n), .xfer_done(xfer_done),
        .rx_shift_byte(rx_shift_byte), .shift_load(shift_load), .shift_data(shift_data),
        .baud_tick(baud_tick), .irq(irq));
    sbf_shifter_model u_far (.pclk(pclk), .presetn(presetn), .halt(halt),
        .shift_load(shift_load), .shift_data(shift_data), .xfer_done(xfer_done),
        .rx_shift_byte(rx_shift_byte));

    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (shift_load === 1'h1) begin
            loads <= loads + 1;
            last <= shift_data;
        end
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ****************************************
    // bus access tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        // ends on pready; only the bench timeout bounds this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wrr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] x;
        logic y;
        apb(1'h1, a, wd, x, y);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] ex);
        logic [31:0] x;
        logic y;
        apb(1'h0, a, 32'h0, x, y);
        `CHK("register read", {24'h000000, ex}, x)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic waitl(input int n);
        while (loads < n) begin
            @(posedge pclk);
        end
    endtask

    task automatic meas(input logic [2:0] p, input logic [2:0] v);
        int n;
        wrr(sbf_pkg::ADDR_BAUD, 32'({p, 1'h0, v}));
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin @(posedge pclk); n++; end while (baud_tick !== 1'h1 && n < 3000);
        end
        `CHK("baud period", (int'(p) + 1) * (2 << v), n)
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 8'h00; pwdata = 32'h0; ss_in_n = 1'h1; halt = 1'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        rdc(sbf_pkg::ADDR_BAUD, 8'h00);
        wrr(sbf_pkg::ADDR_STATUS, 32'hFF);
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        wrr(sbf_pkg::ADDR_BAUD, 32'hFFFFFFFF);
        rdc(sbf_pkg::ADDR_BAUD, 8'h77);
        apb(1'h0, 8'h14, 32'h0, d, e);
        `CHK("unmapped error", 1'h1, e)
        `CHK("unmapped data", 32'h0, d)
        wrr(sbf_pkg::ADDR_CTRL1, 32'h50);
        wrr(sbf_pkg::ADDR_DATA, 32'h11);
        tick(4);
        `CHK("unarmed load", 0, loads)
        meas(3'h0, 3'h0);
        meas(3'h7, 3'h0);
        meas(3'h0, 3'h7);
        meas(3'h2, 3'h3);
        meas(3'h7, 3'h7);
        wrr(sbf_pkg::ADDR_CTRL1, 32'h70);
        tick(3);
        `CHK("tx irq", 1'h1, irq)
        wrr(sbf_pkg::ADDR_CTRL1, 32'h50);
        tick(3);
        `CHK("tx irq masked", 1'h0, irq)
        // two bytes back to back, second queued behind the first
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        wrr(sbf_pkg::ADDR_DATA, 32'hA5);
        tick(3);
        `CHK("first load", 1, loads)
        `CHK("first byte", 8'hA5, last)
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        wrr(sbf_pkg::ADDR_DATA, 32'h3C);
        rdc(sbf_pkg::ADDR_STATUS, 8'h00);
        wrr(sbf_pkg::ADDR_BAUD, 32'h12);
        rdc(sbf_pkg::ADDR_BAUD, 8'h12);
        waitl(2);
        tick(3);
        `CHK("queued byte", 8'h3C, last)
        rdc(sbf_pkg::ADDR_DATA, 8'h5A);
        rdc(sbf_pkg::ADDR_STATUS, 8'hA0);
        tick(30);
        `CHK("no extra load", 2, loads)
        rdc(sbf_pkg::ADDR_DATA, 8'h5A);
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        // disable with a byte in flight, one queued and receive full
        wrr(sbf_pkg::ADDR_DATA, 32'h77);
        tick(3);
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        wrr(sbf_pkg::ADDR_DATA, 32'h88);
        waitl(4);
        tick(2);
        rdc(sbf_pkg::ADDR_STATUS, 8'hA0);
        wrr(sbf_pkg::ADDR_DATA, 32'h99);
        halt <= 1'h1;
        wrr(sbf_pkg::ADDR_CTRL1, 32'h10);
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        wrr(sbf_pkg::ADDR_CTRL1, 32'h50);
        halt <= 1'h0;
        tick(40);
        `CHK("load after disable", 4, loads)
        // mode fault, first with the select output on
        wrr(sbf_pkg::ADDR_CTRL2, 32'hFF);
        rdc(sbf_pkg::ADDR_CTRL2, 8'h1B);
        wrr(sbf_pkg::ADDR_CTRL1, 32'hD2);
        ss_in_n <= 1'h0;
        tick(3);
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        ss_in_n <= 1'h1;
        wrr(sbf_pkg::ADDR_CTRL1, 32'hD0);
        ss_in_n <= 1'h0;
        tick(3);
        `CHK("fault irq", 1'h1, irq)
        wrr(sbf_pkg::ADDR_CTRL1, 32'hD0);
        rdc(sbf_pkg::ADDR_STATUS, 8'h30);
        wrr(sbf_pkg::ADDR_CTRL1, 32'hD0);
        rdc(sbf_pkg::ADDR_STATUS, 8'h20);
        tick(3);
        `CHK("fault irq clear", 1'h0, irq)
        ss_in_n <= 1'h1;
        tick(2);
        wrap_up();
    end
endmodule
